// ==== rtl/sleep_pkg.sv ====
// Purpose: Shared constants for the sleep-mode clock controller.
// Assumes: One 100 MHz clock, synchronous active-high reset.
// Notes: Register offsets index an 8-bit register port.
package sleep_pkg;
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_INDIS = 4'h1;
	localparam logic [3:0] OFS_ANALOG = 4'h2;
	localparam logic [3:0] OFS_STATUS = 4'h3;
	localparam int CTRL_ARM_BIT = 0;
	localparam int CTRL_MODE_LSB = 1;
	localparam int AN_CMP_OFF_BIT = 0;
	localparam int AN_CMP_VREF_BIT = 1;
	localparam int AN_WDT_BIT = 2;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] INDIS_RESET = 8'h00;
	localparam logic [7:0] ANALOG_RESET = 8'h00;
	localparam logic [1:0] MODE_IDLE = 2'h0;
	localparam logic [1:0] MODE_PDOWN_A = 2'h1;
	localparam logic [1:0] MODE_STBY = 2'h2;
	localparam logic [1:0] MODE_PDOWN_B = 2'h3;
	localparam logic [2:0] BOD_FUSE_OFF = 3'h7;
	localparam int STBY_WAKE_CYCLES = 6;
	localparam int CPU_HOLD_CYCLES = 4;
	localparam int PDOWN_STARTUP_CYCLES = 16;
	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_IDLE = 3'b001,
		ST_PDOWN = 3'b010,
		ST_STBY = 3'b011,
		ST_WAKE = 3'b100,
		ST_HOLD = 3'b101
	} sleep_state_e;
endpackage

// ==== rtl/sleep_wake_if.sv ====
// Purpose: Carries sleep depth to the wake gate and the qualified wake back.
// Assumes: Both ends share one clock.
// Notes: Purely combinational signals.
`timescale 1ns/1ps
interface sleep_wake_if;
	logic in_idle;
	logic in_deep;
	logic wake;
	modport ctl (output in_idle, output in_deep, input wake);
	modport gate (input in_idle, input in_deep, output wake);
endinterface

// ==== rtl/wake_gate.sv ====
// Purpose: Qualifies wake-up sources against the current sleep depth.
// Assumes: Source inputs are synchronous levels or pulses.
// Notes: Edge form of the first external interrupt only wakes from Idle.
`timescale 1ns/1ps
module wake_gate (
	sleep_wake_if.gate sw,
	input wire logic i_ext_irq_a_level,
	input wire logic i_ext_irq_a_edge,
	input wire logic i_ext_irq_b,
	input wire logic i_pin_change,
	input wire logic i_univ_serial_if_start,
	input wire logic i_self_prog_ready,
	input wire logic i_other_io_irq
);
	logic deep_src;
	logic any_src;
	assign deep_src = i_ext_irq_a_level | i_ext_irq_b | i_pin_change | i_univ_serial_if_start;
	assign any_src = deep_src | i_ext_irq_a_edge | i_self_prog_ready | i_other_io_irq;
	assign sw.wake = (sw.in_idle & any_src) | (sw.in_deep & deep_src); // [RULE5]
endmodule // wake_gate

// ==== rtl/cycle_counter.sv ====
// Purpose: Loadable down counter that flags the last counted cycle.
// Assumes: i_value is at least one when loaded.
// Notes: o_last is high in the final cycle of the loaded count.
`timescale 1ns/1ps
module cycle_counter #(
	parameter int WIDTH = 5
) (
	input wire logic i_clock,
	input wire logic i_srst,
	input wire logic i_load,
	input wire logic [WIDTH-1:0] i_value,
	output logic o_last
);
	logic [WIDTH-1:0] cnt_r;
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			cnt_r <= '0;
		end else if (i_load) begin
			cnt_r <= i_value;
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - 1'b1;
		end
	end
	assign o_last = (cnt_r == {{(WIDTH-1){1'b0}}, 1'b1}) & ~i_load;
endmodule // cycle_counter

// ==== rtl/sleep_ctrl.sv ====
// Purpose: Sleep-mode sequencer gating CPU, program memory, I/O clocks and oscillator.
// Assumes: Sleep instruction arrives as a one-cycle pulse from the core.
// Notes: Registers: CTRL, input-disable, ANALOG (read/write) and STATUS (read only).
//
// What this block does
// RULE1 - Mode 10 with crystal clock source enters Standby on sleep instruction.
// RULE2 - Standby equals Power-down except the oscillator keeps running.
// RULE3 - Standby wakes within six clock cycles after a valid wake condition.
// RULE4 - Idle stops CPU and memory clocks; Standby keeps oscillator; Power-down stops all.
// RULE5 - Idle wakes on any source; deep modes on external, pin change, serial start.
// RULE6 - Comparator is disabled automatically in every sleep mode but Idle.
// RULE7 - Reference stays on while an enabled comparator uses it.
// RULE8 - Reference is on when detector or comparator needs it, off otherwise; code keeps it on in deep sleep while the disabled comparator selects it.
// RULE9 - Brown-out detector enabled by fuse stays active in all sleep modes.
// RULE10 - An enabled watchdog keeps running in every sleep mode.
// RULE11 - With I/O clock stopped, input buffers are off except wake pins.
// RULE12 - Buffers disabled by software stay disabled at all times.
// RULE13 - Mode 00 selects Idle; modes 01 and 11 select Power-down.
// RULE14 - Sleep instruction only acts when the arm bit is already set.
// RULE15 - After waking, CPU is held four more cycles before servicing.
// RULE16 - Standby wake delay comes from a counter on the running oscillator.
`timescale 1ns/1ps
module sleep_ctrl #(
	parameter int PDOWN_STARTUP = sleep_pkg::PDOWN_STARTUP_CYCLES,
	parameter logic [7:0] WAKE_PIN_MASK = 8'h0C
) (
	input wire logic i_clock,
	input wire logic i_srst,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_sleep_instr,
	input wire logic i_xtal_selected,
	input wire logic [2:0] i_brownout_threshold_fuse,
	input wire logic i_ext_irq_a_level,
	input wire logic i_ext_irq_a_edge,
	input wire logic i_ext_irq_b,
	input wire logic i_pin_change,
	input wire logic i_univ_serial_if_start,
	input wire logic i_self_prog_ready,
	input wire logic i_other_io_irq,
	output logic o_cpu_clk_en,
	output logic o_pmem_clk_en,
	output logic o_io_clk_en,
	output logic o_osc_en,
	output logic o_cpu_hold,
	output logic o_irq_service,
	output logic o_cmp_en,
	output logic o_vref_en,
	output logic o_bod_en,
	output logic o_wdt_en,
	output logic [7:0] o_inbuf_en
);
	localparam int CW = 16;

	logic [7:0] ctrl_r;
	logic [7:0] indis_r;
	logic [7:0] analog_r;
	sleep_pkg::sleep_state_e state_r;
	sleep_pkg::sleep_state_e state_nxt;
	logic sleep_arm;
	logic [1:0] sleep_mode_select;
	logic cmp_off;
	logic cmp_uses_vref;
	logic bod_on;
	logic wake_load;
	logic [CW-1:0] wake_value;
	logic wake_last;
	logic hold_load;
	logic hold_last;
	logic deep_nxt;
	logic io_stop_nxt;
	logic [7:0] rdata_nxt;

	sleep_wake_if sw ();

	assign sleep_arm = ctrl_r[sleep_pkg::CTRL_ARM_BIT];
	assign sleep_mode_select = ctrl_r[sleep_pkg::CTRL_MODE_LSB +: 2];
	assign cmp_off = analog_r[sleep_pkg::AN_CMP_OFF_BIT];
	assign cmp_uses_vref = analog_r[sleep_pkg::AN_CMP_VREF_BIT];
	assign bod_on = i_brownout_threshold_fuse != sleep_pkg::BOD_FUSE_OFF;
	assign sw.in_idle = state_r == sleep_pkg::ST_IDLE;
	assign sw.in_deep = (state_r == sleep_pkg::ST_PDOWN) | (state_r == sleep_pkg::ST_STBY);

	wake_gate u_wake_gate (
		.sw(sw.gate),
		.i_ext_irq_a_level(i_ext_irq_a_level),
		.i_ext_irq_a_edge(i_ext_irq_a_edge),
		.i_ext_irq_b(i_ext_irq_b),
		.i_pin_change(i_pin_change),
		.i_univ_serial_if_start(i_univ_serial_if_start),
		.i_self_prog_ready(i_self_prog_ready),
		.i_other_io_irq(i_other_io_irq)
	);

	// Restart delay runs on the oscillator clock, which Standby leaves running
	cycle_counter #(.WIDTH(CW)) u_wake_cnt (
		.i_clock(i_clock),
		.i_srst(i_srst),
		.i_load(wake_load),
		.i_value(wake_value),
		.o_last(wake_last)
	); // [RULE16]

	cycle_counter #(.WIDTH(CW)) u_hold_cnt (
		.i_clock(i_clock),
		.i_srst(i_srst),
		.i_load(hold_load),
		.i_value(CW'(sleep_pkg::CPU_HOLD_CYCLES)),
		.o_last(hold_last)
	);

	always_comb begin
		state_nxt = state_r;
		wake_load = 1'b0;
		wake_value = CW'(PDOWN_STARTUP);
		hold_load = 1'b0;
		case (state_r)
			sleep_pkg::ST_RUN: begin
				if (i_sleep_instr && sleep_arm) begin // [RULE14]
					case (sleep_mode_select)
						sleep_pkg::MODE_IDLE: state_nxt = sleep_pkg::ST_IDLE; // [RULE13]
						sleep_pkg::MODE_STBY: begin
							// Without a crystal the oscillator is not worth keeping
							state_nxt = i_xtal_selected ? sleep_pkg::ST_STBY
								: sleep_pkg::ST_PDOWN; // [RULE1]
						end
						default: state_nxt = sleep_pkg::ST_PDOWN; // [RULE13]
					endcase
				end
			end
			sleep_pkg::ST_IDLE: begin
				if (sw.wake) begin
					hold_load = 1'b1;
					state_nxt = sleep_pkg::ST_HOLD;
				end
			end
			sleep_pkg::ST_PDOWN, sleep_pkg::ST_STBY: begin
				if (sw.wake) begin
					wake_load = 1'b1;
					if (state_r == sleep_pkg::ST_STBY) begin
						wake_value = CW'(sleep_pkg::STBY_WAKE_CYCLES); // [RULE3]
					end
					state_nxt = sleep_pkg::ST_WAKE;
				end
			end
			sleep_pkg::ST_WAKE: begin
				if (wake_last) begin
					hold_load = 1'b1;
					state_nxt = sleep_pkg::ST_HOLD;
				end
			end
			sleep_pkg::ST_HOLD: begin
				if (hold_last) begin
					state_nxt = sleep_pkg::ST_RUN; // [RULE15]
				end
			end
			default: state_nxt = sleep_pkg::ST_RUN;
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			state_r <= sleep_pkg::ST_RUN;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			ctrl_r <= sleep_pkg::CTRL_RESET;
			indis_r <= sleep_pkg::INDIS_RESET;
			analog_r <= sleep_pkg::ANALOG_RESET;
		end else if (i_wr) begin
			case (i_addr)
				sleep_pkg::OFS_CTRL: ctrl_r <= {5'h00, i_wdata[2:0]};
				sleep_pkg::OFS_INDIS: indis_r <= i_wdata;
				sleep_pkg::OFS_ANALOG: analog_r <= {5'h00, i_wdata[2:0]};
				default: ;
			endcase
		end
	end

	always_comb begin
		case (i_addr)
			sleep_pkg::OFS_CTRL: rdata_nxt = ctrl_r;
			sleep_pkg::OFS_INDIS: rdata_nxt = indis_r;
			sleep_pkg::OFS_ANALOG: rdata_nxt = analog_r;
			sleep_pkg::OFS_STATUS: rdata_nxt = {o_cpu_clk_en, o_io_clk_en, o_osc_en,
				o_cpu_hold, o_vref_en, state_r};
			default: rdata_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_rdata <= 8'h00;
		end else begin
			o_rdata <= i_rd ? rdata_nxt : 8'h00;
		end
	end

	assign deep_nxt = (state_nxt == sleep_pkg::ST_PDOWN) | (state_nxt == sleep_pkg::ST_STBY);
	assign io_stop_nxt = deep_nxt | (state_nxt == sleep_pkg::ST_WAKE);

	// Clock enables follow the next state so they line up with state_r
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_cpu_clk_en <= 1'b1;
			o_pmem_clk_en <= 1'b1;
			o_io_clk_en <= 1'b1;
			o_osc_en <= 1'b1;
			o_cpu_hold <= 1'b0;
			o_irq_service <= 1'b0;
		end else begin
			o_cpu_clk_en <= (state_nxt == sleep_pkg::ST_RUN) |
				(state_nxt == sleep_pkg::ST_HOLD); // [RULE4]
			o_pmem_clk_en <= (state_nxt == sleep_pkg::ST_RUN) |
				(state_nxt == sleep_pkg::ST_HOLD); // [RULE4]
			o_io_clk_en <= ~io_stop_nxt; // [RULE4]
			o_osc_en <= state_nxt != sleep_pkg::ST_PDOWN; // [RULE2] [RULE4]
			o_cpu_hold <= state_nxt == sleep_pkg::ST_HOLD; // [RULE15]
			o_irq_service <= (state_r == sleep_pkg::ST_HOLD) & hold_last;
		end
	end

	// Reference stays up through sleep, so it is usable at once on wake
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_cmp_en <= 1'b0;
			o_vref_en <= 1'b0;
			o_bod_en <= 1'b0;
			o_wdt_en <= 1'b0;
			o_inbuf_en <= 8'h00;
		end else begin
			o_cmp_en <= ~cmp_off & ~deep_nxt; // [RULE6]
			o_vref_en <= bod_on | (cmp_uses_vref & ~cmp_off); // [RULE7] [RULE8]
			o_bod_en <= bod_on; // [RULE9]
			o_wdt_en <= analog_r[sleep_pkg::AN_WDT_BIT]; // [RULE10]
			o_inbuf_en <= ~indis_r & (io_stop_nxt ? WAKE_PIN_MASK : 8'hFF); // [RULE11] [RULE12]
		end
	end

	sequence s_stby_wake;
		(state_r == sleep_pkg::ST_STBY) && sw.wake;
	endsequence

	sequence s_restart;
		(state_r == sleep_pkg::ST_WAKE && o_osc_en && !o_cpu_clk_en) [*6];
	endsequence

	sequence s_hold;
		(state_r == sleep_pkg::ST_HOLD && o_cpu_hold) [*4];
	endsequence

	property p_arm;
		@(posedge i_clock) disable iff (i_srst)
		(state_r == sleep_pkg::ST_RUN && i_sleep_instr && !sleep_arm)
			|=> state_r == sleep_pkg::ST_RUN;
	endproperty
	a_arm: assert property (p_arm) else $error("Sleep entered while not armed"); // [RULE14]

	property p_mode_sel;
		@(posedge i_clock) disable iff (i_srst)
		(state_r == sleep_pkg::ST_RUN && i_sleep_instr && sleep_arm)
			|=> (state_r == ($past(sleep_mode_select) == sleep_pkg::MODE_IDLE
				? sleep_pkg::ST_IDLE
				: ($past(sleep_mode_select) == sleep_pkg::MODE_STBY && $past(i_xtal_selected))
				? sleep_pkg::ST_STBY : sleep_pkg::ST_PDOWN));
	endproperty
	a_mode_sel: assert property (p_mode_sel) else $error("Wrong sleep mode entered"); // [RULE13]

	property p_stby_entry;
		@(posedge i_clock) disable iff (i_srst)
		(state_r == sleep_pkg::ST_RUN && i_sleep_instr && sleep_arm && i_xtal_selected &&
			sleep_mode_select == sleep_pkg::MODE_STBY) |=> o_osc_en && !o_io_clk_en;
	endproperty
	a_stby_entry: assert property (p_stby_entry) else $error("Standby not entered"); // [RULE1]

	property p_stby_wake;
		@(posedge i_clock) disable iff (i_srst)
		s_stby_wake |=> s_restart ##1 (state_r == sleep_pkg::ST_HOLD && o_cpu_clk_en);
	endproperty
	a_stby_wake: assert property (p_stby_wake) else $error("Standby wake not six cycles"); // [RULE3]

	property p_hold;
		@(posedge i_clock) disable iff (i_srst)
		(state_r != sleep_pkg::ST_HOLD ##1 state_r == sleep_pkg::ST_HOLD)
			|-> s_hold ##1 (state_r == sleep_pkg::ST_RUN && o_irq_service);
	endproperty
	a_hold: assert property (p_hold) else $error("CPU hold not four cycles"); // [RULE15]

	property p_gating;
		@(posedge i_clock) disable iff (i_srst)
		((state_r == sleep_pkg::ST_IDLE) |-> !o_cpu_clk_en && !o_pmem_clk_en && o_io_clk_en
			&& o_osc_en) and
		((state_r == sleep_pkg::ST_PDOWN) |-> !o_io_clk_en && !o_osc_en && !o_cpu_clk_en);
	endproperty
	a_gating: assert property (p_gating) else $error("Clock gating wrong for mode"); // [RULE4]

	property p_stby_osc;
		@(posedge i_clock) disable iff (i_srst)
		(state_r == sleep_pkg::ST_STBY) |-> o_osc_en && !o_io_clk_en && !o_pmem_clk_en;
	endproperty
	a_stby_osc: assert property (p_stby_osc) else $error("Standby oscillator wrong"); // [RULE2]

	property p_deep_src;
		@(posedge i_clock) disable iff (i_srst)
		(sw.in_deep && !i_ext_irq_a_level && !i_ext_irq_b && !i_pin_change &&
			!i_univ_serial_if_start)
			|=> $stable(state_r);
	endproperty
	a_deep_src: assert property (p_deep_src) else $error("Deep sleep woke on bad source"); // [RULE5]

	property p_cmp;
		@(posedge i_clock) disable iff (i_srst)
		sw.in_deep |-> !o_cmp_en;
	endproperty
	a_cmp: assert property (p_cmp) else $error("Comparator on in deep sleep"); // [RULE6]

	property p_vref;
		@(posedge i_clock) disable iff (i_srst)
		1'b1 |=> o_vref_en == ($past(bod_on) || ($past(cmp_uses_vref) && !$past(cmp_off)));
	endproperty
	a_vref: assert property (p_vref) else $error("Reference enable wrong"); // [RULE7] [RULE8]

	property p_bod_wdt;
		@(posedge i_clock) disable iff (i_srst)
		1'b1 |=> o_bod_en == $past(bod_on) &&
			o_wdt_en == $past(analog_r[sleep_pkg::AN_WDT_BIT]);
	endproperty
	a_bod_wdt: assert property (p_bod_wdt) else $error("Detector or watchdog gated"); // [RULE9] [RULE10]

	property p_inbuf;
		@(posedge i_clock) disable iff (i_srst)
		1'b1 |=> ((o_inbuf_en & $past(indis_r)) == 8'h00) &&
			(o_io_clk_en || ((o_inbuf_en & ~WAKE_PIN_MASK) == 8'h00));
	endproperty
	a_inbuf: assert property (p_inbuf) else $error("Input buffer enabled wrongly"); // [RULE11] [RULE12]
endmodule // sleep_ctrl

// ==== test/wake_src_model.sv ====
// Purpose: Far-side wake sources; a fired line stays high until serviced or dropped.
// Assumes: Bench pulses i_fire for one cycle together with i_sel.
// Notes: Lines are levels, since a level interrupt must be held to wake deep sleep.
`timescale 1ns/1ps
module wake_src_model (
	input wire logic i_clock,
	input wire logic i_srst,
	input wire logic i_fire,
	input wire logic [2:0] i_sel,
	input wire logic i_drop,
	input wire logic i_serviced,
	output logic [6:0] o_src
);
	logic [6:0] held_r;
	always_ff @(posedge i_clock) begin
		if (i_srst || i_drop || i_serviced) begin
			held_r <= 7'h00;
		end else if (i_fire) begin
			held_r <= 7'h01 << i_sel;
		end
	end
	// Fire shows at once so the bench knows the exact cycle the source rose
	assign o_src = held_r | (i_fire ? (7'h01 << i_sel) : 7'h00);
endmodule // wake_src_model

// ==== test/sleep_mode_clock_gating_bench.sv ====
// Purpose: Self-checking bench for the sleep sequencer.
// Assumes: Sources 0 irq A level, 1 irq A edge, 2 irq B, 3 pin change, 4 serial start,
//          5 store ready, 6 other io.
// Notes: Power-down restart shortened to keep the run brief.
`timescale 1ns/1ps
module sleep_mode_clock_gating_bench;
	localparam int PD = 3;
	localparam logic [7:0] WPM = 8'h0C;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic sleep = 1'b0;
	logic xtal = 1'b0;
	logic [2:0] fuse = 3'h7;
	logic fire = 1'b0;
	logic [2:0] sel = 3'h0;
	logic drop = 1'b0;
	logic [6:0] src;
	logic [7:0] rdata, inbuf, indis, an;
	logic cpu_en, pmem_en, io_en, osc_en, hold, svc, cmp_en, vref_en, bod_en, wdt_en;
	int bad_count = 0;
	int samples_checked = 0;
	int seed = 53945;

	always #5 clock = ~clock;

	sleep_ctrl #(.PDOWN_STARTUP(PD), .WAKE_PIN_MASK(WPM)) DUT (.i_clock(clock), .i_srst(srst),
		.i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.i_sleep_instr(sleep), .i_xtal_selected(xtal), .i_brownout_threshold_fuse(fuse),
		.i_ext_irq_a_level(src[0]), .i_ext_irq_a_edge(src[1]), .i_ext_irq_b(src[2]),
		.i_pin_change(src[3]), .i_univ_serial_if_start(src[4]), .i_self_prog_ready(src[5]),
		.i_other_io_irq(src[6]), .o_cpu_clk_en(cpu_en), .o_pmem_clk_en(pmem_en),
		.o_io_clk_en(io_en), .o_osc_en(osc_en), .o_cpu_hold(hold), .o_irq_service(svc),
		.o_cmp_en(cmp_en), .o_vref_en(vref_en), .o_bod_en(bod_en), .o_wdt_en(wdt_en),
		.o_inbuf_en(inbuf));

	wake_src_model partner (.i_clock(clock), .i_srst(srst), .i_fire(fire), .i_sel(sel),
		.i_drop(drop), .i_serviced(svc), .o_src(src));

	task automatic close_out;
		$display("checks %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic cmp_bit(input string what, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %b, seen %b", what, exp, got);
		end
	endtask

	task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr <= 1'b0;
	endtask

	task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clock);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic sleep_pulse;
		@(posedge clock);
		sleep <= 1'b1;
		@(posedge clock);
		sleep <= 1'b0;
		#1;
	endtask

	// k: 0 run, 1 idle, 2 power-down, 3 standby
	function automatic logic [1:0] kind_of(input logic [1:0] m, input logic x);
		if (m == 2'h0) return 2'h1;
		return (m == 2'h2 && x) ? 2'h3 : 2'h2;
	endfunction

	task automatic check_side(input logic [1:0] k);
		logic lt;
		lt = (k < 2'h2);
		cmp_bit("cpu clock", k == 2'h0, cpu_en);
		cmp_bit("memory clock", k == 2'h0, pmem_en);
		cmp_bit("io clock", lt, io_en);
		cmp_bit("oscillator", k != 2'h2, osc_en);
		cmp_bit("comparator", lt & ~an[0], cmp_en);
		cmp_bit("reference", (fuse != 3'h7) | (an[1] & ~an[0]), vref_en);
		cmp_bit("detector", fuse != 3'h7, bod_en);
		cmp_bit("watchdog", an[2], wdt_en);
		cmp_byte("input buffers", lt ? ~indis : (~indis & WPM), inbuf);
	endtask

	task automatic wake_and_count(input logic [2:0] s, input logic [1:0] k);
		int n;
		int m;
		int exp;
		n = 0;
		m = 0;
		exp = (k == 2'h1) ? 1 : (k == 2'h2) ? 1 + PD : 1 + sleep_pkg::STBY_WAKE_CYCLES;
		@(posedge clock);
		fire <= 1'b1;
		sel <= s;
		while (hold !== 1'b1 && n < 40) begin
			@(posedge clock);
			fire <= 1'b0;
			#1;
			n++;
			if (n == 1 && k != 2'h1) begin
				cmp_bit("cpu clock in wake", 1'b0, cpu_en);
				if (k == 2'h3) cmp_bit("oscillator in wake", 1'b1, osc_en);
			end
		end
		cmp_byte("wake latency", 8'(exp), 8'(n));
		while (hold === 1'b1 && m < 20) begin
			cmp_bit("cpu clock in hold", 1'b1, cpu_en);
			@(posedge clock);
			#1;
			m++;
		end
		if (n >= 40 || m >= 20) begin
			bad_count++;
			return;
		end
		cmp_byte("hold cycles", 8'(sleep_pkg::CPU_HOLD_CYCLES), 8'(m));
		cmp_bit("service pulse", 1'b1, svc);
		check_side(2'h0);
	endtask

	initial begin
		int i;
		logic [7:0] d;
		logic [1:0] mode;
		logic [1:0] k;
		logic [2:0] s;
		indis = 8'h00;
		an = 8'h00;
		repeat (8) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		#1;
		check_side(2'h0);
		reg_wr(4'h9, 8'hFF);
		reg_rd(sleep_pkg::OFS_CTRL, d);
		cmp_byte("control", sleep_pkg::CTRL_RESET, d);
		reg_rd(sleep_pkg::OFS_ANALOG, d);
		cmp_byte("analog", sleep_pkg::ANALOG_RESET, d);
		reg_rd(4'hF, d);
		cmp_byte("unmapped", 8'h00, d);
		reg_rd(sleep_pkg::OFS_STATUS, d);
		cmp_byte("status", 8'hE0, d);
		reg_wr(sleep_pkg::OFS_CTRL, 8'(sleep_pkg::MODE_PDOWN_A) << sleep_pkg::CTRL_MODE_LSB);
		sleep_pulse;
		cmp_bit("unarmed cpu clock", 1'b1, cpu_en);
		$display("test reset and unarmed done");
		for (i = 0; i < 12; i++) begin
			mode = (i < 4) ? i[1:0] : 2'($random(seed));
			@(posedge clock);
			xtal <= (i == 2) ? 1'b1 : (i == 4) ? 1'b0 : 1'($random(seed));
			if (i == 4) mode = sleep_pkg::MODE_STBY;
			indis = 8'($random(seed));
			an = 8'($random(seed)) & 8'h07;
			fuse <= 3'($random(seed));
			reg_wr(sleep_pkg::OFS_INDIS, indis);
			reg_wr(sleep_pkg::OFS_ANALOG, an);
			reg_wr(sleep_pkg::OFS_CTRL, (8'(mode) << sleep_pkg::CTRL_MODE_LSB) | 8'h01);
			reg_rd(sleep_pkg::OFS_INDIS, d);
			cmp_byte("disable register", indis, d);
			k = kind_of(mode, xtal);
			sleep_pulse;
			check_side(k);
			if (k != 2'h1) begin
				s = (i % 3 == 0) ? 3'h1 : (i % 3 == 1) ? 3'h5 : 3'h6;
				@(posedge clock);
				fire <= 1'b1;
				sel <= s;
				@(posedge clock);
				fire <= 1'b0;
				repeat (3) @(posedge clock);
				drop <= 1'b1;
				@(posedge clock);
				drop <= 1'b0;
				#1;
				cmp_bit("asleep after foreign source", 1'b0, cpu_en | hold);
				s = (i % 4 == 0) ? 3'h0 : 3'(2 + i % 3);
			end else begin
				s = 3'(i % 7);
			end
			wake_and_count(s, k);
			$display("test %0d mode %0d source %0d done", i, mode, s);
		end
		close_out;
	end
endmodule // sleep_mode_clock_gating_bench
